// File: dv/tb_top.sv
// Self-checking bench for the converter control block: register port,
// conversion timing, interrupt and wake levels.
// Assumes a short bit step and a comparator level held steady per run.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ********************************************************
    // Signals and instance
    // ********************************************************
    localparam int         STEP = 4;
    localparam int         CONV = 8 * STEP + 1;
    localparam logic [7:0] CTL  = adci_pkg::ADCI_CONTROL_OFS;
    localparam logic [7:0] RES  = adci_pkg::ADCI_RESULT_OFS;
    logic       i_core_clk = 1'b0;
    logic       i_rst_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic       i_cmp_above = 1'b0;
    logic       i_stop_mode = 1'b0;
    logic       i_wait_mode = 1'b0;
    wire  [7:0] o_rdata, o_trial_code;
    wire        o_converter_en, o_main_osc_disable, o_irq, o_wake;
    // Status levels gathered so a check can read them after they settle
    wire  [3:0] lv = {o_main_osc_disable, o_converter_en, o_wake, o_irq};
    localparam int L_IRQ = 0, L_WAKE = 1, L_CEN = 2, L_OSC = 3;
    logic [7:0] exp_q[$];
    logic       rd_pend = 1'b0;
    logic [31:0] seed = 32'd52657;
    int         n_fail = 0;
    int         samples_checked = 0;
    int         cyc = 0;
    logic [7:0] v, a;
    adci_top #(.STEP_CYC(STEP)) u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_cmp_above(i_cmp_above), .i_stop_mode(i_stop_mode), .i_wait_mode(i_wait_mode),
        .o_trial_code(o_trial_code), .o_converter_en(o_converter_en),
        .o_main_osc_disable(o_main_osc_disable), .o_irq(o_irq), .o_wake(o_wake));
    always #2.5 i_core_clk = ~i_core_clk;
    // ********************************************************
    // Tasks
    // ********************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One-cycle strobes; a returning task leaves one edge before the next one
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= ad;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= ad;
        exp_q.push_back(exp);
        @(posedge i_core_clk);
        i_rd <= 1'b0;
    endtask
    // Level read at mid-cycle, never in the launching time step
    task automatic lvl(input string nm, input int sel, input logic exp);
        @(negedge i_core_clk);
        chk(nm, {7'h00, lv[sel]}, {7'h00, exp});
    endtask
    task automatic tdone(input string nm);
        $display("test %s finished", nm);
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ********************************************************
    // Read data monitor and timeout
    // ********************************************************
    // Read data stand only one cycle, so sample them mid-cycle
    always @(posedge i_core_clk) rd_pend <= i_rd;
    always @(negedge i_core_clk) begin
        if (rd_pend) chk("o_rdata", o_rdata, exp_q.pop_front());
    end
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            end_of_test();
        end
    end
    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        repeat (20) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        rd(CTL, 8'h40);
        rd(RES, 8'h00);
        rd(8'h55, 8'h00);
        lvl("o_irq", L_IRQ, 1'b0);
        wr(CTL, 8'h10);
        rd(CTL, 8'h50);
        lvl("o_converter_en", L_CEN, 1'b1);
        tdone("reset_power");
        // Comparator raised just before start, settled ahead of the first decision: full scale expected
        i_cmp_above <= 1'b1;
        wr(CTL, 8'hB0);
        i_wait_mode <= 1'b1;
        rd(CTL, 8'h90);
        @(negedge i_core_clk);
        chk("o_trial_code", o_trial_code, 8'h80);
        lvl("o_wake", L_WAKE, 1'b0);
        lvl("o_irq", L_IRQ, 1'b0);
        repeat (CONV) @(posedge i_core_clk);
        rd(CTL, 8'hD0);
        rd(RES, 8'hFF);
        lvl("o_irq", L_IRQ, 1'b1);
        i_wait_mode <= 1'b1;
        lvl("o_wake", L_WAKE, 1'b1);
        i_stop_mode <= 1'b1;
        lvl("o_wake", L_WAKE, 1'b0);
        lvl("o_converter_en", L_CEN, 1'b0);
        i_stop_mode <= 1'b0;
        i_wait_mode <= 1'b0;
        wr(CTL, 8'h10);
        lvl("o_irq", L_IRQ, 1'b0);
        rd(CTL, 8'h50);
        tdone("convert_irq");
        // Restart mid-conversion; first run's finish time must pass quietly
        i_cmp_above <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        wr(CTL, 8'h30);
        repeat (12) @(posedge i_core_clk);
        wr(CTL, 8'h30);
        repeat (18) @(posedge i_core_clk);
        rd(CTL, 8'h10);
        repeat (CONV) @(posedge i_core_clk);
        rd(CTL, 8'h50);
        rd(RES, 8'h00);
        tdone("restart");
        // Random settings with start low, plus stray and read-only writes
        for (int k = 0; k < 8; k++) begin
            v = 8'(rnd());
            v = {v[7], 3'b001, 1'b0, v[2], 2'b00};
            wr(CTL, v);
            rd(CTL, {v[7], 3'b101, 1'b0, v[2], 2'b00});
            lvl("o_main_osc_disable", L_OSC, v[2]);
            lvl("o_irq", L_IRQ, v[7]);
            a = 8'(rnd());
            a = a & 8'hEF;
            wr(a, 8'hFF);
            rd(a, 8'h00);
            wr(RES, 8'h5A);
            rd(RES, 8'h00);
            rd(CTL, {v[7], 3'b101, 1'b0, v[2], 2'b00});
        end
        tdone("random_regs");
        repeat (4) @(posedge i_core_clk);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire

// File: hw/adci_top.sv
// Control and status logic of the 8-bit successive-approximation converter.
// Assumes the analog comparator answer arrives asynchronously on a pin and
// that the core's low-power state is given as plain wait and stop levels.
`timescale 1ns/1ps
`default_nettype none

module adci_top #(
    parameter int STEP_CYC = adci_pkg::ADCI_STEP_CYC
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_cmp_above,     // Analog input above trial level
    input  wire logic       i_stop_mode,
    input  wire logic       i_wait_mode,
    output logic      [7:0] o_trial_code,    // Trial code fed to the analog DAC
    output logic            o_converter_en,
    output logic            o_main_osc_disable,
    output logic            o_irq,
    output logic            o_wake
);

    // ********************************************************
    // Comparator synchroniser
    // ********************************************************
    logic [2:0] cmp_sync_r;
    logic       cmp_r;
    logic       cmp_nxt;

    // Third and second stage must agree before a change counts
    always_comb begin
        cmp_nxt = cmp_r;
        if (cmp_sync_r[2] == cmp_sync_r[1]) begin
            cmp_nxt = cmp_sync_r[2];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cmp_sync_r <= 3'h0;
            cmp_r      <= 1'b0;
        end else begin
            cmp_sync_r <= {cmp_sync_r[1:0], i_cmp_above};
            cmp_r      <= cmp_nxt;
        end
    end

    // ********************************************************
    // Register and conversion state
    // ********************************************************
    adci_pkg::adci_ctrl_t  ctrl_r,   ctrl_nxt;
    adci_pkg::adci_state_t state_r,  state_nxt;
    logic                  done_r,   done_nxt;
    logic [7:0]            result_r, result_nxt;
    logic [7:0]            trial_r,  trial_nxt;
    logic [2:0]            bit_r,    bit_nxt;
    logic [15:0]           step_r,   step_nxt;
    logic [7:0]            rdata_r,  rdata_nxt;
    logic                  wr_ctrl;
    logic                  start_req;
    logic                  conv_ok;
    logic                  step_tick;
    logic                  finish;

    assign wr_ctrl   = i_wr && (i_addr == adci_pkg::ADCI_CONTROL_OFS);
    // Zero in the start position does nothing
    assign start_req = wr_ctrl && i_wdata[adci_pkg::ADCI_BIT_START];
    // Converter runs only powered and outside stop; wait changes nothing
    assign conv_ok   = ctrl_r.power_on && !i_stop_mode;
    assign step_tick = (step_r == 16'(STEP_CYC - 1));
    assign finish    = (state_r == adci_pkg::ADCI_CONV) && conv_ok && step_tick
                       && (bit_r == 3'h0);

    // Next-state logic for registers and the successive-approximation walk
    always_comb begin
        ctrl_nxt   = ctrl_r;
        state_nxt  = state_r;
        done_nxt   = done_r;
        result_nxt = result_r;
        trial_nxt  = trial_r;
        bit_nxt    = bit_r;
        step_nxt   = step_r;
        if (wr_ctrl) begin
            ctrl_nxt.irq_en   = i_wdata[adci_pkg::ADCI_BIT_IRQ_EN];
            ctrl_nxt.power_on = i_wdata[adci_pkg::ADCI_BIT_POWER];
            ctrl_nxt.rsvd3    = i_wdata[3];
            ctrl_nxt.osc_off  = i_wdata[adci_pkg::ADCI_BIT_OSC_OFF];
            ctrl_nxt.rsvd_lo  = i_wdata[1:0];
        end
        unique case (state_r)
            adci_pkg::ADCI_IDLE: begin
                step_nxt = 16'h0000;
            end
            adci_pkg::ADCI_CONV: begin
                if (!conv_ok) begin
                    // Losing power or entering stop abandons the conversion
                    state_nxt = adci_pkg::ADCI_IDLE;
                end else if (step_tick) begin
                    step_nxt = 16'h0000;
                    // Keep the trial bit only if input is above it
                    if (!cmp_r) begin
                        trial_nxt[bit_r] = 1'b0;
                    end
                    if (bit_r == 3'h0) begin
                        // Result changes on the last step; the flag rises with it unless a start in the same cycle holds it low
                        result_nxt = cmp_r ? trial_r : (trial_r & ~8'h01);
                        done_nxt   = 1'b1;
                        state_nxt  = adci_pkg::ADCI_IDLE;
                    end else begin
                        bit_nxt = bit_r - 3'h1;
                        trial_nxt[bit_r - 3'h1] = 1'b1;
                    end
                end else begin
                    step_nxt = step_r + 16'h0001;
                end
            end
            default: begin
                state_nxt = adci_pkg::ADCI_IDLE;
            end
        endcase
        // A start wins over the walk and the done flag, restarting any running walk; a result finishing in that cycle is still stored
        if (start_req) begin
            done_nxt  = 1'b0;
            state_nxt = adci_pkg::ADCI_CONV;
            bit_nxt   = 3'h7;
            trial_nxt = 8'h80;
            step_nxt  = 16'h0000;
        end
    end

    // Read mux; start reads zero, done flag read-only
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_rd) begin
            if (i_addr == adci_pkg::ADCI_RESULT_OFS) begin
                rdata_nxt = result_r;
            end else if (i_addr == adci_pkg::ADCI_CONTROL_OFS) begin
                rdata_nxt = {ctrl_r.irq_en, done_r, 1'b0, ctrl_r.power_on,
                             ctrl_r.rsvd3, ctrl_r.osc_off, ctrl_r.rsvd_lo};
            end
        end
    end

    // Reset places control at its documented value
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ctrl_r   <= '0;
            done_r   <= adci_pkg::ADCI_CONTROL_RST[adci_pkg::ADCI_BIT_DONE];
            state_r  <= adci_pkg::ADCI_IDLE;
            result_r <= adci_pkg::ADCI_RESULT_RST;
            trial_r  <= 8'h00;
            bit_r    <= 3'h0;
            step_r   <= 16'h0000;
            rdata_r  <= 8'h00;
        end else begin
            ctrl_r   <= ctrl_nxt;
            done_r   <= done_nxt;
            state_r  <= state_nxt;
            result_r <= result_nxt;
            trial_r  <= trial_nxt;
            bit_r    <= bit_nxt;
            step_r   <= step_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign o_rdata            = rdata_r;
    assign o_trial_code       = trial_r;
    assign o_converter_en     = conv_ok;
    assign o_main_osc_disable = ctrl_r.osc_off;
    // Done flag gated by enable; level stays until start or enable clear
    assign o_irq              = done_r && ctrl_r.irq_en;
    // Wake only leaves wait; stop ignores the converter event
    assign o_wake             = o_irq && i_wait_mode && !i_stop_mode;

    // ********************************************************
    // Checks
    // ********************************************************
    AST_START_CLEARS_DONE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        start_req |=> !done_r && state_r == adci_pkg::ADCI_CONV && trial_r == 8'h80)
        else $error("start did not clear flag or begin");

    AST_RESTART: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (state_r == adci_pkg::ADCI_CONV && bit_r != 3'h7 && start_req) |=> bit_r == 3'h7)
        else $error("restart ignored");

    AST_FINISH_SETS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (finish && !start_req) |=> done_r && state_r == adci_pkg::ADCI_IDLE)
        else $error("finish did not set flag");

    AST_DONE_STICKY: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (done_r && !start_req) |=> done_r)
        else $error("flag cleared without start");

    AST_START_READS_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == adci_pkg::ADCI_CONTROL_OFS) |=> !o_rdata[adci_pkg::ADCI_BIT_START])
        else $error("start bit read nonzero");

    AST_IRQ_GATE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_irq == (done_r && ctrl_r.irq_en))
        else $error("irq not gated by enable");

    AST_RESULT_READ: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == adci_pkg::ADCI_RESULT_OFS) |=> o_rdata == $past(result_r))
        else $error("result read mismatch");

    AST_RESULT_STABLE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (done_r && $past(done_r)) |-> $stable(result_r))
        else $error("result changed while valid");

    AST_POWER_OFF: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (state_r == adci_pkg::ADCI_CONV && !ctrl_r.power_on && !start_req)
            |=> state_r == adci_pkg::ADCI_IDLE)
        else $error("conversion continued unpowered");

    AST_NO_STOP_WAKE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_stop_mode |-> !o_wake && !o_converter_en)
        else $error("converter active in stop");

endmodule // adci_top

`default_nettype wire

// File: inc/adci_pkg.sv
// Constants, register map and carrier types for the converter control block.
// Assumes a plain register port from the core and a successive-approximation
// analog macro that takes one comparator decision per bit step.
package adci_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] ADCI_RESULT_OFS  = 8'hD0;
    localparam logic [7:0] ADCI_CONTROL_OFS = 8'hD1;
    localparam logic [7:0] ADCI_CONTROL_RST = 8'h40;
    localparam logic [7:0] ADCI_RESULT_RST  = 8'h00;

    // Control field positions
    localparam int ADCI_BIT_IRQ_EN   = 7;
    localparam int ADCI_BIT_DONE     = 6;
    localparam int ADCI_BIT_START    = 5;
    localparam int ADCI_BIT_POWER    = 4;
    localparam int ADCI_BIT_OSC_OFF  = 2;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int ADCI_CLK_MHZ      = 200;
    localparam int ADCI_STEP_NS      = 500;   // One bit decision per step
    localparam int ADCI_STEP_CYC     = (ADCI_STEP_NS * ADCI_CLK_MHZ + 999) / 1000;
    localparam int ADCI_NBITS        = 8;

    // ********************************************************
    // Carrier types
    // ********************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adci_bus_req_t;

    typedef struct packed {
        logic irq_en;
        logic power_on;
        logic rsvd3;
        logic osc_off;
        logic [1:0] rsvd_lo;
    } adci_ctrl_t;

    typedef enum logic [1:0] {
        ADCI_IDLE,
        ADCI_CONV
    } adci_state_t;

endpackage
